// [rtl/tcc_pkg.sv]
// Package for the 16-bit timer capture and compare units.
// Assumes an APB slave with 32-bit data, one register per aligned word.
package tcc_pkg;

	// ------------------------------------------------------------------
	// Register byte offsets
	// ------------------------------------------------------------------
	localparam logic [7:0] TCC_CTRL_OFS = 8'h00;
	localparam logic [7:0] TCC_FLAG_OFS = 8'h04;
	localparam logic [7:0] TCC_FORCE_OFS = 8'h08;
	localparam logic [7:0] TCC_CNT_LO_OFS = 8'h0C;
	localparam logic [7:0] TCC_CNT_HI_OFS = 8'h10;
	localparam logic [7:0] TCC_CAP_LO_OFS = 8'h14;
	localparam logic [7:0] TCC_CAP_HI_OFS = 8'h18;
	localparam logic [7:0] TCC_CMPA_LO_OFS = 8'h1C;
	localparam logic [7:0] TCC_CMPA_HI_OFS = 8'h20;
	localparam logic [7:0] TCC_CMPB_LO_OFS = 8'h24;
	localparam logic [7:0] TCC_CMPB_HI_OFS = 8'h28;

	// ------------------------------------------------------------------
	// Control register fields
	// ------------------------------------------------------------------
	localparam int TCC_WGM_LSB = 0;
	localparam int TCC_FILT_BIT = 4;
	localparam int TCC_EDGE_BIT = 5;
	localparam int TCC_ACMP_BIT = 6;
	localparam int TCC_CAPIE_BIT = 7;
	localparam int TCC_CMPIE_LSB = 8;
	localparam int TCC_COM_LSB = 10;
	localparam int TCC_CTRL_W = 14;
	localparam logic [13:0] TCC_CTRL_RST = 14'h0000;

	// Flag register bits
	localparam int TCC_CAPF_BIT = 0;
	localparam int TCC_CMPF_LSB = 1;

	// ------------------------------------------------------------------
	// Waveform modes of interest
	// ------------------------------------------------------------------
	localparam logic [3:0] TCC_MODE_NORMAL = 4'h0;
	localparam logic [3:0] TCC_MODE_CTC_CMP = 4'h4;
	localparam logic [3:0] TCC_MODE_CTC_CAP = 4'hC;
	localparam logic [3:0] TCC_MODE_RSVD = 4'hD;

	// Compare output actions in non-PWM modes
	localparam logic [1:0] TCC_COM_NONE = 2'h0;
	localparam logic [1:0] TCC_COM_TOGGLE = 2'h1;
	localparam logic [1:0] TCC_COM_CLEAR = 2'h2;
	localparam logic [1:0] TCC_COM_SET = 2'h3;

	// Noise filter depth in samples
	localparam int TCC_FILT_DEPTH = 4;

endpackage : tcc_pkg

// [rtl/tcc_filter.sv]
// Input conditioning for the capture trigger: pin synchroniser plus
// optional majority-free noise filter. Assumes i_raw is asynchronous.
`timescale 1ns/100ps
module tcc_filter
	import tcc_pkg::*;
(
	input wire logic i_clk, // system clock
	input wire logic i_srst, // synchronous reset
	input wire logic i_raw, // asynchronous trigger level
	input wire logic i_enable, // noise filter enable
	output logic o_level // conditioned level
);

	logic [2:0] sync_reg;
	logic stable_reg;
	logic [TCC_FILT_DEPTH-2:0] hist_reg;
	logic filt_reg;

	// ------------------------------------------------------------------
	// Three-stage synchroniser, change taken when stages two and three agree
	// ------------------------------------------------------------------
	always_ff @(posedge i_clk)
	begin
		if (i_srst)
			sync_reg <= 3'h0;
		else
			sync_reg <= {sync_reg[1:0], i_raw};
	end

	always_ff @(posedge i_clk)
	begin
		if (i_srst)
			stable_reg <= 1'b0;
		else if (sync_reg[1] == sync_reg[2])
			stable_reg <= sync_reg[2];
	end

	// ------------------------------------------------------------------
	// Filter runs on the undivided clock, no prescaler involvement
	// ------------------------------------------------------------------
	always_ff @(posedge i_clk)
	begin
		if (i_srst)
			hist_reg <= '0;
		else
			hist_reg <= {hist_reg[TCC_FILT_DEPTH-3:0], stable_reg};
	end

	always_ff @(posedge i_clk)
	begin
		if (i_srst)
			filt_reg <= 1'b0;
		// Three held samples and the newest one make four
		else if (&{hist_reg, stable_reg} || ~|{hist_reg, stable_reg})
			filt_reg <= stable_reg;
	end

	assign o_level = i_enable ? filt_reg : stable_reg;

endmodule : tcc_filter

// [rtl/tcc_compare.sv]
// One compare channel: compare register, its buffer, flag and output
// state. Assumes i_tick is the one-cycle timer clock enable.
`timescale 1ns/100ps
module tcc_compare
	import tcc_pkg::*;
(
	input wire logic i_clk, // system clock
	input wire logic i_srst, // synchronous reset
	input wire logic i_tick, // timer clock enable
	input wire logic [15:0] i_counter_value, // counter value
	input wire logic i_buffered, // double buffering active
	input wire logic i_pwm, // any PWM mode
	input wire logic i_update, // buffer to compare transfer point
	input wire logic i_block, // match blocked by counter write
	input wire logic i_wr, // 16-bit write strobe
	input wire logic [15:0] i_wdata, // 16-bit write value
	input wire logic i_force, // force compare strobe
	input wire logic [1:0] i_com, // compare output mode
	input wire logic i_clr, // flag clear strobe
	output logic [15:0] o_cpu_view, // value seen by reads
	output logic [15:0] o_compare, // active compare value
	output logic o_match, // match event pulse
	output logic o_flag, // compare flag
	output logic o_state // compare output state
);

	logic [15:0] cmp_reg;
	logic [15:0] buf_reg;
	logic hit;

	assign hit = i_tick && !i_block && (i_counter_value == cmp_reg);
	assign o_match = hit;
	assign o_compare = cmp_reg;
	assign o_cpu_view = i_buffered ? buf_reg : cmp_reg;

	always_ff @(posedge i_clk)
	begin
		if (i_srst)
			buf_reg <= 16'h0000;
		else if (i_wr)
			buf_reg <= i_wdata;
	end

	always_ff @(posedge i_clk)
	begin
		if (i_srst)
			cmp_reg <= 16'h0000;
		else if (i_wr && !i_buffered)
			cmp_reg <= i_wdata;
		else if (i_buffered && i_update)
			cmp_reg <= buf_reg;
	end

	// Set beats clear when both land in one cycle
	always_ff @(posedge i_clk)
	begin
		if (i_srst)
			o_flag <= 1'b0;
		else if (hit)
			o_flag <= 1'b1;
		else if (i_clr)
			o_flag <= 1'b0;
	end

	// Kept across mode changes; PWM waveforms belong to the generator
	always_ff @(posedge i_clk)
	begin
		if (i_srst)
			o_state <= 1'b0;
		else if ((hit || (i_force && !i_pwm)) && !i_pwm)
		begin
			case (i_com)
				TCC_COM_TOGGLE: o_state <= ~o_state;
				TCC_COM_CLEAR: o_state <= 1'b0;
				TCC_COM_SET: o_state <= 1'b1;
				default: o_state <= o_state;
			endcase
		end
	end

endmodule : tcc_compare

// [rtl/tcc_top.sv]
// Capture and compare units of a 16-bit timer, reached over APB.
// Assumes the counter, prescaler and waveform generator sit outside;
// they supply the count, timer tick and TOP/BOTTOM strobes.
//
// Contract
// - A qualified trigger edge copies the 16-bit counter into capture.
// - Capture flag sets in the same cycle the counter is copied.
// - Capture flag requests irq when enabled; clears on ack or write-one.
// - Capture low read loads temp with high byte; high read returns temp.
// - Capture writable only in TOP modes; high byte written before low.
// - Control bit picks comparator as trigger; switching may capture.
// - Filter output changes only after four equal consecutive samples.
// - Filter adds four system cycles, runs on undivided clock.
// - Edge detector active except in capture-TOP modes; filter always runs.
// - New capture overwrites capture register even if unread.
// - Software driving the pin's port level can trigger a capture.
// - Compare flag requests irq when enabled; clears on ack or write-one.
// - Compare double buffered in twelve PWM modes, updated at TOP/BOTTOM.
// - CPU reaches buffer when buffered, else compare; reads skip temp.
// - High write loads temp; low write moves temp into upper byte.
// - Force in non-PWM acts like a match, no flag, no counter action.
// - Any counter write blocks matches in the next timer tick.
// - Compare output state survives waveform mode changes.
// - Compare output mode bits act immediately, unbuffered.
// - Compare output mode zero leaves the state unchanged on match.
`timescale 1ns/100ps
module tcc_top
	import tcc_pkg::*;
(
	input wire logic i_clk, // system clock, 200 MHz
	input wire logic i_srst, // synchronous reset, active high
	input wire logic i_psel, // APB select
	input wire logic i_penable, // APB enable
	input wire logic i_pwrite, // APB direction
	input wire logic [7:0] i_paddr, // APB byte address
	input wire logic [31:0] i_pwdata, // APB write data
	output logic [31:0] o_prdata, // APB read data
	output logic o_pready, // APB ready
	output logic o_pslverr, // APB error, unmapped address
	input wire logic i_capture_pin, // capture pin level, asynchronous
	input wire logic i_comparator_output, // comparator level, asynchronous
	input wire logic i_timer_tick, // one-cycle timer clock enable
	input wire logic [15:0] i_counter_value, // running counter value
	input wire logic i_counter_top, // counter at TOP this cycle
	input wire logic i_counter_bottom, // counter at BOTTOM this cycle
	input wire logic i_capture_irq_ack, // capture irq executed pulse
	input wire logic [1:0] i_compare_irq_ack, // compare irq executed pulses
	output logic o_counter_load, // counter write pulse
	output logic [15:0] o_counter_load_value, // counter write value
	output logic [3:0] o_waveform_mode_select, // waveform mode to counter
	output logic [15:0] o_capture_register, // capture value, TOP source
	output logic [15:0] o_compare_a_value, // active compare A value
	output logic [1:0] o_compare_match, // match event pulses
	output logic [1:0] o_compare_output_state, // compare output states
	output logic o_capture_irq, // capture interrupt request
	output logic [1:0] o_compare_irq // compare interrupt requests
);

	import tcc_pkg::*;

	// ------------------------------------------------------------------
	// Declarations
	// ------------------------------------------------------------------
	logic [TCC_CTRL_W-1:0] ctrl_reg;
	logic [7:0] temp_reg;
	logic [15:0] capture_reg;
	logic capture_flag_reg;
	logic edge_prev_reg;
	logic block_reg;
	logic load_reg;
	logic [15:0] load_value_reg;

	logic wr_access;
	logic rd_access;
	logic [7:0] wbyte;
	logic [3:0] mode;
	logic cap_is_top;
	logic pwm_mode;
	logic bottom_update;
	logic update_point;

	logic trig_raw;
	logic trig_level;
	logic trig_edge;

	logic addr_ok;
	logic hi_wr;
	logic cnt_lo_wr;
	logic cap_lo_wr;
	logic flag_wr;
	logic force_wr;

	logic [1:0] cmp_wr;
	logic [1:0] cmp_force;
	logic [1:0] cmp_clr;
	logic [15:0] cmp_view [2];
	logic [15:0] cmp_active [2];
	logic [1:0] cmp_flag;

	logic [31:0] rdata_next;

	// ------------------------------------------------------------------
	// Mode decode
	// ------------------------------------------------------------------
	assign mode = ctrl_reg[TCC_WGM_LSB +: 4];
	assign o_waveform_mode_select = mode;

	// Capture as TOP in modes 8, 10, 12 and 14
	assign cap_is_top = mode[3] && !mode[0];

	// Every mode except normal, both clear-on-match modes and the reserved one
	assign pwm_mode = (mode != TCC_MODE_NORMAL) && (mode != TCC_MODE_CTC_CMP)
		&& (mode != TCC_MODE_CTC_CAP) && (mode != TCC_MODE_RSVD);

	// Phase and frequency correct modes reload at BOTTOM, the others at TOP
	assign bottom_update = (mode[3:1] == 3'b100);
	assign update_point = i_timer_tick
		&& (bottom_update ? i_counter_bottom : i_counter_top);

	// ------------------------------------------------------------------
	// APB decode
	// ------------------------------------------------------------------
	assign wr_access = i_psel && i_penable && i_pwrite;
	assign rd_access = i_psel && i_penable && !i_pwrite;
	assign wbyte = i_pwdata[7:0];
	// Zero wait states on every access
	assign o_pready = 1'b1;

	// One strobe shared by the four high bytes, one per other written location
	assign hi_wr = wr_access && (i_paddr == TCC_CNT_HI_OFS
		|| i_paddr == TCC_CAP_HI_OFS
		|| i_paddr == TCC_CMPA_HI_OFS
		|| i_paddr == TCC_CMPB_HI_OFS);
	assign cnt_lo_wr = wr_access && i_paddr == TCC_CNT_LO_OFS;
	assign cap_lo_wr = wr_access && i_paddr == TCC_CAP_LO_OFS;
	assign flag_wr = wr_access && i_paddr == TCC_FLAG_OFS;
	assign force_wr = wr_access && i_paddr == TCC_FORCE_OFS;

	always_comb
	begin
		case (i_paddr)
			TCC_CTRL_OFS, TCC_FLAG_OFS, TCC_FORCE_OFS,
			TCC_CNT_LO_OFS, TCC_CNT_HI_OFS,
			TCC_CAP_LO_OFS, TCC_CAP_HI_OFS,
			TCC_CMPA_LO_OFS, TCC_CMPA_HI_OFS,
			TCC_CMPB_LO_OFS, TCC_CMPB_HI_OFS: addr_ok = 1'b1;
			default: addr_ok = 1'b0;
		endcase
	end

	// Unmapped offsets answer with an error
	assign o_pslverr = i_psel && i_penable && !addr_ok;

	// ------------------------------------------------------------------
	// Control register
	// ------------------------------------------------------------------
	always_ff @(posedge i_clk)
	begin
		if (i_srst)
			ctrl_reg <= TCC_CTRL_RST;
		else if (wr_access && i_paddr == TCC_CTRL_OFS)
			ctrl_reg <= i_pwdata[TCC_CTRL_W-1:0];
	end

	// ------------------------------------------------------------------
	// Shared high-byte temporary register
	// ------------------------------------------------------------------
	// One temp serves all 16-bit registers, so an interrupting access
	// between the two halves corrupts the outer one.
	always_ff @(posedge i_clk)
	begin
		if (i_srst)
			temp_reg <= 8'h00;
		else if (hi_wr)
			temp_reg <= wbyte;
		else if (rd_access && i_paddr == TCC_CAP_LO_OFS)
			temp_reg <= capture_reg[15:8];
		else if (rd_access && i_paddr == TCC_CNT_LO_OFS)
			temp_reg <= i_counter_value[15:8];
	end

	// ------------------------------------------------------------------
	// Counter write and match blocking
	// ------------------------------------------------------------------
	always_ff @(posedge i_clk)
	begin
		if (i_srst)
			load_reg <= 1'b0;
		else
			load_reg <= cnt_lo_wr;
	end

	always_ff @(posedge i_clk)
	begin
		if (i_srst)
			load_value_reg <= 16'h0000;
		else if (cnt_lo_wr)
			load_value_reg <= {temp_reg, wbyte};
	end

	assign o_counter_load = load_reg;
	assign o_counter_load_value = load_value_reg;

	// Held across a stopped timer until the next tick consumes it
	always_ff @(posedge i_clk)
	begin
		if (i_srst)
			block_reg <= 1'b0;
		else if (cnt_lo_wr)
			block_reg <= 1'b1;
		else if (i_timer_tick)
			block_reg <= 1'b0;
	end

	// ------------------------------------------------------------------
	// Capture trigger path
	// ------------------------------------------------------------------
	// The pad level already includes any port drive from software,
	// so a port toggle reaches this path like an external edge.
	assign trig_raw = ctrl_reg[TCC_ACMP_BIT] ? i_comparator_output
		: i_capture_pin;

	tcc_filter u_filter (
		.i_clk(i_clk),
		.i_srst(i_srst),
		.i_raw(trig_raw),
		.i_enable(ctrl_reg[TCC_FILT_BIT]),
		.o_level(trig_level)
	);

	// Resets low like an idle input: no edge at release
	always_ff @(posedge i_clk)
	begin
		if (i_srst)
			edge_prev_reg <= 1'b0;
		else
			edge_prev_reg <= trig_level;
	end

	// Held off while capture sets TOP
	assign trig_edge = !cap_is_top && (ctrl_reg[TCC_EDGE_BIT]
		? (trig_level && !edge_prev_reg)
		: (!trig_level && edge_prev_reg));

	// ------------------------------------------------------------------
	// Capture register and flag
	// ------------------------------------------------------------------
	always_ff @(posedge i_clk)
	begin
		if (i_srst)
			capture_reg <= 16'h0000;
		else if (trig_edge)
			capture_reg <= i_counter_value;
		// A capture beats a same-cycle CPU write
		else if (cap_lo_wr && cap_is_top)
			capture_reg <= {temp_reg, wbyte};
	end

	assign o_capture_register = capture_reg;

	// Set beats a clear arriving in the same cycle
	always_ff @(posedge i_clk)
	begin
		if (i_srst)
			capture_flag_reg <= 1'b0;
		else if (trig_edge)
			capture_flag_reg <= 1'b1;
		else if (i_capture_irq_ack
			|| (flag_wr && i_pwdata[TCC_CAPF_BIT]))
			capture_flag_reg <= 1'b0;
	end

	assign o_capture_irq = capture_flag_reg
		&& ctrl_reg[TCC_CAPIE_BIT];

	// ------------------------------------------------------------------
	// Compare channels
	// ------------------------------------------------------------------
	assign cmp_wr[0] = wr_access && i_paddr == TCC_CMPA_LO_OFS;
	assign cmp_wr[1] = wr_access && i_paddr == TCC_CMPB_LO_OFS;

	generate
		for (genvar ch = 0; ch < 2; ch++)
		begin : g_ch
			assign cmp_force[ch] = force_wr && i_pwdata[ch];
			assign cmp_clr[ch] = i_compare_irq_ack[ch] || (flag_wr
				&& i_pwdata[TCC_CMPF_LSB + ch]);
			assign o_compare_irq[ch] = cmp_flag[ch]
				&& ctrl_reg[TCC_CMPIE_LSB + ch];

			tcc_compare u_cmp (
				.i_clk(i_clk),
				.i_srst(i_srst),
				.i_tick(i_timer_tick),
				.i_counter_value(i_counter_value),
				.i_buffered(pwm_mode),
				.i_pwm(pwm_mode),
				.i_update(update_point),
				.i_block(block_reg),
				.i_wr(cmp_wr[ch]),
				.i_wdata({temp_reg, wbyte}),
				.i_force(cmp_force[ch]),
				.i_com(ctrl_reg[TCC_COM_LSB + 2*ch +: 2]),
				.i_clr(cmp_clr[ch]),
				.o_cpu_view(cmp_view[ch]),
				.o_compare(cmp_active[ch]),
				.o_match(o_compare_match[ch]),
				.o_flag(cmp_flag[ch]),
				.o_state(o_compare_output_state[ch])
			);
		end
	endgenerate

	assign o_compare_a_value = cmp_active[0];

	// ------------------------------------------------------------------
	// Read data
	// ------------------------------------------------------------------
	always_comb
	begin
		rdata_next = 32'h0000_0000;
		case (i_paddr)
			TCC_CTRL_OFS: rdata_next[TCC_CTRL_W-1:0] = ctrl_reg;
			TCC_FLAG_OFS: rdata_next[2:0] = {cmp_flag, capture_flag_reg};
			TCC_CNT_LO_OFS: rdata_next[7:0] = i_counter_value[7:0];
			TCC_CNT_HI_OFS: rdata_next[7:0] = temp_reg;
			TCC_CAP_LO_OFS: rdata_next[7:0] = capture_reg[7:0];
			TCC_CAP_HI_OFS: rdata_next[7:0] = temp_reg;
			TCC_CMPA_LO_OFS: rdata_next[7:0] = cmp_view[0][7:0];
			TCC_CMPA_HI_OFS: rdata_next[7:0] = cmp_view[0][15:8];
			TCC_CMPB_LO_OFS: rdata_next[7:0] = cmp_view[1][7:0];
			TCC_CMPB_HI_OFS: rdata_next[7:0] = cmp_view[1][15:8];
			default: rdata_next = 32'h0000_0000;
		endcase
	end

	// Zero outside a read's access phase
	assign o_prdata = rd_access ? rdata_next : 32'h0000_0000;

endmodule : tcc_top

// [verification/tcc_event_model.sv]
// Event source standing at the capture and comparator inputs.
// Assumes the bench commands the levels; edges land off the clock grid.
`timescale 1ns/100ps
module tcc_event_model
(
	input wire logic i_pin_req, // requested pin level
	input wire logic i_cmp_req, // requested comparator level
	output logic o_capture_pin, // pin level, asynchronous
	output logic o_comparator_output // comparator level, asynchronous
);
	// Skew keeps edges away from the receiver's sampling edge
	assign #1.3 o_capture_pin = i_pin_req;
	assign #2.1 o_comparator_output = i_cmp_req;
endmodule : tcc_event_model

// [verification/tcc_checker.sv]
// Concurrent checks on the ports of tcc_top.
// Assumes one clock domain and a zero wait state APB slave.
`timescale 1ns/100ps
module tcc_checker
	import tcc_pkg::*;
(
	input wire logic i_clk, // system clock
	input wire logic i_srst, // synchronous reset
	input wire logic i_psel, // APB select
	input wire logic i_penable, // APB enable
	input wire logic i_pwrite, // APB direction
	input wire logic [7:0] i_paddr, // APB address
	input wire logic [31:0] i_pwdata, // APB write data
	input wire logic i_timer_tick, // timer clock enable
	input wire logic [15:0] i_counter_value, // counter value
	input wire logic i_counter_top, // counter at TOP
	input wire logic i_counter_bottom, // counter at BOTTOM
	input wire logic [1:0] i_compare_irq_ack, // compare irq executed
	input wire logic [15:0] o_capture_register, // capture value
	input wire logic [15:0] o_compare_a_value, // active compare A
	input wire logic [1:0] o_compare_match, // match pulses
	input wire logic [1:0] o_compare_output_state, // output states
	input wire logic [1:0] o_compare_irq // compare irq requests
);
	import tcc_pkg::*;
	default clocking cb @(posedge i_clk);
	endclocking
	default disable iff (i_srst);
	logic wr_acc;
	logic pend_reg;
	assign wr_acc = i_psel && i_penable && i_pwrite;
	// Tracks the first tick after a counter write
	always_ff @(posedge i_clk)
	begin
		if (i_srst)
			pend_reg <= 1'b0;
		else if (wr_acc && i_paddr == TCC_CNT_LO_OFS)
			pend_reg <= 1'b1;
		else if (i_timer_tick)
			pend_reg <= 1'b0;
	end
	sequence s_flag_clr;
		wr_acc && i_paddr == TCC_FLAG_OFS && i_pwdata[1];
	endsequence
	chk_match_equal: assert property (o_compare_match[0] |->
		i_timer_tick && i_counter_value == o_compare_a_value)
		else $error("match without equal count");
	chk_write_block: assert property (pend_reg && i_timer_tick |->
		o_compare_match == 2'b00)
		else $error("match after counter write");
	chk_capture_copy: assert property ($changed(o_capture_register) &&
		!$past(i_srst) && !$past(wr_acc) |->
		o_capture_register == $past(i_counter_value))
		else $error("capture value not the counter");
	chk_state_cause: assert property ($changed(o_compare_output_state[0]) &&
		!$past(i_srst) |-> $past(o_compare_match[0]) ||
		$past(wr_acc && i_paddr == TCC_FORCE_OFS))
		else $error("output state moved without cause");
	chk_irq_cause: assert property ($rose(o_compare_irq[0]) |->
		$past(o_compare_match[0]) || $past(wr_acc && i_paddr == TCC_CTRL_OFS))
		else $error("compare irq without match");
	chk_ack_clear: assert property (i_compare_irq_ack[0] &&
		!o_compare_match[0] |=> !o_compare_irq[0])
		else $error("compare irq kept after ack");
	chk_flag_w1c: assert property (s_flag_clr and !o_compare_match[0]
		|=> !o_compare_irq[0])
		else $error("compare flag kept after write one");
	chk_cmp_update: assert property ($changed(o_compare_a_value) &&
		!$past(i_srst) |-> $past(wr_acc && i_paddr == TCC_CMPA_LO_OFS) ||
		$past(i_timer_tick && (i_counter_top || i_counter_bottom)))
		else $error("compare value moved off update point");
endmodule : tcc_checker
bind tcc_top tcc_checker u_tcc_checker (.*);

// [verification/test_tcc_top.sv]
// Self-checking bench for the capture and compare units.
// Assumes the event model and checker are compiled before it.
`timescale 1ns/100ps
module test_tcc_top;
	import tcc_pkg::*;
	logic clk = 0;
	logic srst = 1;
	logic psel = 0;
	logic pen = 0;
	logic pwr = 0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0000_0000;
	logic [31:0] rdata;
	logic [31:0] prdata;
	logic tick = 0;
	logic top = 0;
	logic pin_req = 0;
	logic cmp_req = 0;
	logic cap_ack = 0;
	logic [1:0] cmp_ack = 2'h0;
	logic [1:0] match, state, cmp_irq;
	logic [15:0] cnt = 16'h0000;
	logic [15:0] ld_val, cap_reg, cmpa;
	logic [3:0] wgm;
	logic pready, pslverr, ld, pin, acmp, cap_irq, err_seen;
	int errors = 0;
	int comparisons = 0;
	int n;
	always #2.5 clk = ~clk;
	tcc_event_model u_tcc_event_model (.i_pin_req(pin_req),
		.i_cmp_req(cmp_req), .o_capture_pin(pin), .o_comparator_output(acmp));
	tcc_top u_tcc_top (.i_clk(clk), .i_srst(srst), .i_psel(psel),
		.i_penable(pen), .i_pwrite(pwr), .i_paddr(paddr), .i_pwdata(pwdata),
		.o_prdata(prdata), .o_pready(pready), .o_pslverr(pslverr),
		.i_capture_pin(pin), .i_comparator_output(acmp), .i_timer_tick(tick),
		.i_counter_value(cnt), .i_counter_top(top), .i_counter_bottom(1'b0),
		.i_capture_irq_ack(cap_ack), .i_compare_irq_ack(cmp_ack),
		.o_counter_load(ld), .o_counter_load_value(ld_val),
		.o_waveform_mode_select(wgm), .o_capture_register(cap_reg),
		.o_compare_a_value(cmpa), .o_compare_match(match),
		.o_compare_output_state(state), .o_capture_irq(cap_irq),
		.o_compare_irq(cmp_irq));
	// ------------------------------------------------------------------
	// Shared tasks
	// ------------------------------------------------------------------
	task automatic check(input logic [15:0] got, input logic [15:0] exp);
		comparisons++;
		if (got !== exp)
		begin
			errors++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : check
	task automatic xfer(input logic [7:0] a, input logic w,
		input logic [15:0] d);
		@(posedge clk);
		psel <= 1;
		paddr <= a;
		pwr <= w;
		pwdata <= {16'h0000, d};
		@(posedge clk);
		pen <= 1;
		do @(posedge clk); while (pready !== 1'b1);
		rdata = prdata;
		err_seen = pslverr;
		psel <= 0;
		pen <= 0;
	endtask : xfer
	task automatic cyc(input int k);
		repeat (k) @(negedge clk);
	endtask : cyc
	task automatic pulse_tick(input logic [15:0] v, input logic t);
		@(posedge clk);
		cnt <= v;
		tick <= 1;
		top <= t;
		@(posedge clk);
		tick <= 0;
		top <= 0;
		cyc(1);
	endtask : pulse_tick
	task automatic set_src(input logic p, input logic c);
		@(posedge clk);
		pin_req <= p;
		cmp_req <= c;
		cyc(15);
	endtask : set_src
	task automatic wait_cap(output int k);
		k = 0;
		while (cap_irq !== 1'b1 && k < 40)
		begin
			@(negedge clk);
			k++;
		end
	endtask : wait_cap
	task automatic report_and_stop();
		$display("comparisons %0d errors %0d", comparisons, errors);
		if (errors == 0 && comparisons > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask : report_and_stop
	// ------------------------------------------------------------------
	// Scenarios
	// ------------------------------------------------------------------
	task automatic t_compare();
		xfer(TCC_CMPA_HI_OFS, 1, 16'h0012);
		xfer(TCC_CMPA_LO_OFS, 1, 16'h0034);
		cyc(1);
		check(cmpa, 16'h1234);
		xfer(TCC_CMPB_HI_OFS, 1, 16'h0077);
		xfer(TCC_CMPA_HI_OFS, 0, 16'h0000);
		check(rdata[15:0], 16'h0012);
		xfer(TCC_CTRL_OFS, 1, 16'h0005);
		xfer(TCC_CMPA_LO_OFS, 1, 16'h0056);
		cyc(1);
		check(cmpa, 16'h1234);
		xfer(TCC_CMPA_HI_OFS, 0, 16'h0000);
		check(rdata[15:0], 16'h0077);
		pulse_tick(16'h0000, 1);
		check(cmpa, 16'h7756);
		xfer(TCC_CTRL_OFS, 1, 16'h0000);
		xfer(TCC_CMPA_HI_OFS, 1, 16'h0012);
		xfer(TCC_CMPA_LO_OFS, 1, 16'h0034);
	endtask : t_compare
	task automatic t_match();
		xfer(TCC_CTRL_OFS, 1, 16'h0100);
		pulse_tick(16'h1234, 0);
		check(cmp_irq, 16'h0001);
		check(state, 16'h0000);
		xfer(TCC_FLAG_OFS, 1, 16'h0002);
		cyc(1);
		check(cmp_irq, 16'h0000);
		xfer(TCC_CTRL_OFS, 1, 16'h0500);
		pulse_tick(16'h1234, 0);
		check(state, 16'h0001);
		@(posedge clk);
		cmp_ack <= 2'h3;
		@(posedge clk);
		cmp_ack <= 2'h0;
		cyc(1);
		check(cmp_irq, 16'h0000);
	endtask : t_match
	task automatic t_force();
		xfer(TCC_CTRL_OFS, 1, 16'h0900);
		xfer(TCC_FORCE_OFS, 1, 16'h0001);
		cyc(1);
		check(state, 16'h0000);
		check(cmp_irq, 16'h0000);
		xfer(TCC_CTRL_OFS, 1, 16'h0D00);
		xfer(TCC_FORCE_OFS, 1, 16'h0001);
		xfer(TCC_CTRL_OFS, 1, 16'h0D04);
		cyc(1);
		check(state, 16'h0001);
		check(wgm, 16'h0004);
	endtask : t_force
	task automatic t_block();
		xfer(TCC_CNT_HI_OFS, 1, 16'h0012);
		xfer(TCC_CNT_LO_OFS, 1, 16'h0034);
		cyc(1);
		check(ld, 16'h0001);
		cyc(4);
		pulse_tick(16'h1234, 0);
		check(cmp_irq, 16'h0000);
		check(ld_val, 16'h1234);
		pulse_tick(16'h1234, 0);
		check(cmp_irq, 16'h0001);
		xfer(TCC_CTRL_OFS, 1, 16'h00A0);
	endtask : t_block
	task automatic t_capture();
		pulse_tick(16'hABCD, 0);
		@(posedge clk);
		pin_req <= 1;
		wait_cap(n);
		check(16'(n), 16'h0006);
		check(cap_reg, 16'hABCD);
		xfer(TCC_CAP_LO_OFS, 0, 16'h0000);
		check(rdata[15:0], 16'h00CD);
		xfer(TCC_CAP_HI_OFS, 0, 16'h0000);
		check(rdata[15:0], 16'h00AB);
		pulse_tick(16'h5555, 0);
		set_src(0, 0);
		check(cap_reg, 16'hABCD);
		set_src(1, 0);
		check(cap_reg, 16'h5555);
		@(posedge clk);
		cap_ack <= 1;
		@(posedge clk);
		cap_ack <= 0;
		cyc(1);
		check(cap_irq, 16'h0000);
	endtask : t_capture
	task automatic t_filter();
		xfer(TCC_CTRL_OFS, 1, 16'h00B0);
		set_src(0, 0);
		xfer(TCC_FLAG_OFS, 1, 16'h0001);
		pulse_tick(16'h0F0F, 0);
		@(posedge clk);
		pin_req <= 1;
		repeat (2) @(posedge clk);
		pin_req <= 0;
		cyc(15);
		check(cap_irq, 16'h0000);
		@(posedge clk);
		pin_req <= 1;
		wait_cap(n);
		check(16'(n), 16'h000A);
		check(cap_reg, 16'h0F0F);
	endtask : t_filter
	task automatic t_source();
		xfer(TCC_CTRL_OFS, 1, 16'h00E0);
		xfer(TCC_FLAG_OFS, 1, 16'h0001);
		pulse_tick(16'h00C3, 0);
		check(cap_irq, 16'h0000);
		@(posedge clk);
		cmp_req <= 1;
		wait_cap(n);
		check(cap_reg, 16'h00C3);
		set_src(1, 0);
	endtask : t_source
	task automatic t_top();
		xfer(TCC_CAP_HI_OFS, 1, 16'h0001);
		xfer(TCC_CAP_LO_OFS, 1, 16'h0002);
		cyc(1);
		check(cap_reg, 16'h00C3);
		xfer(TCC_CTRL_OFS, 1, 16'h00EC);
		xfer(TCC_CAP_HI_OFS, 1, 16'h0001);
		xfer(TCC_CAP_LO_OFS, 1, 16'h0002);
		cyc(1);
		check(cap_reg, 16'h0102);
		set_src(1, 1);
		check(cap_reg, 16'h0102);
		xfer(8'h2C, 0, 16'h0000);
		check(16'(err_seen), 16'h0001);
		check(rdata[15:0], 16'h0000);
	endtask : t_top
	// ------------------------------------------------------------------
	// Main sequence and watchdog
	// ------------------------------------------------------------------
	initial
	begin
		repeat (20) @(posedge clk);
		srst <= 0;
		t_compare();
		t_match();
		t_force();
		t_block();
		t_capture();
		t_filter();
		t_source();
		t_top();
		report_and_stop();
	end
	initial
	begin
		#(5 * 20000);
		errors++;
		report_and_stop();
	end
endmodule : test_tcc_top
